// File: pkg/epc_regs.vh
// Constants for the programmer that drives a 16K x 8 programmable read-only memory.
// Assumes one 125 MHz clock; EPC_PULSE_CYC, EPC_SETUP_CYC and EPC_ACCESS_CYC below are in cycles of that clock.
//
// What the document requires
// R1: Device drives addressed byte when chip and output enables low, normal supply.
// R2: Chip enabled, output enable high: device floats its data lines.
// R3: Chip enable high puts the device in standby with data floating.
// R4: Raised supply, output off, chip on, burn strobe low: device programs.
// R5: Programmer presents the whole byte on eight data lines while programming.
// R6: Burn strobe falls only after address and data stand stable, held through.
// R7: Pulses last 100 microseconds, each followed by read-back of the byte.
// R8: At most 10 pulses per byte; still failing after tenth means byte failed.
// R9: Verify with raised supply, chip and output on, strobe high: byte driven.
// R10: Chip enable or strobe high under raised supply inhibits programming.
// R11: After the run, every location is re-read at normal supply and compared; the code re-reads only the location named by each check command.
// R12: Blank device reads all ones; programming only clears bits.
// R13: On one-time parts a cleared bit stays cleared forever.
// R14: Locations may be programmed in any order; parallel devices together.
// R15: Elevated voltage on id address pin selects identifier bytes.
// R16: Id select low gives maker code, high gives device type code.
// R17: Host holds all other address inputs low while reading identifiers.
// R18: Array holds 16384 bytes of eight bits, fourteen address inputs.
// R19: On good verify move to next address; stop and report on failed byte.
`ifndef EPC_REGS_VH
`define EPC_REGS_VH

`define EPC_ADDR_W 14
`define EPC_DATA_W 8
`define EPC_CLK_MHZ 125
`define EPC_PULSE_US 100
`define EPC_PULSE_CYC (`EPC_PULSE_US * `EPC_CLK_MHZ)
`define EPC_MAX_PULSES 4'hA
`define EPC_SETUP_CYC 8'h04
`define EPC_ACCESS_CYC 8'h20
`define EPC_ID_MFG_SEL 1'b0
`define EPC_ID_DEV_SEL 1'b1

`endif

// File: rtl/epc_prog.v
// Programmer controller: reads, programs with pulse-and-verify, checks the addressed location
// afterwards on each check command and reads identifier bytes of the memory on its pins.
// Assumes the memory's data lines are resolved outside from data_oe.
`include "epc_regs.vh"
module epc_prog #(
  parameter PULSE_CYC = `EPC_PULSE_CYC
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  input wire clk_en,
  // User command port
  input wire cmd_valid,
  input wire [1:0] cmd_op,
  input wire [13:0] cmd_addr,
  input wire [7:0] cmd_data,
  input wire cmd_last,
  output reg cmd_ready_q,
  output reg rsp_valid_q,
  output reg [7:0] rsp_data_q,
  output reg rsp_err_q,
  output reg [3:0] rsp_pulses_q,
  // Memory pins
  output reg [13:0] addr_in_q,
  output reg chip_on_n_q,
  output reg output_on_n_q,
  output reg burn_pulse_n_q,
  output reg vpp_high_q,
  output reg vcc_high_q,
  output reg id_hv_q,
  output reg [7:0] data_out_q,
  output reg data_oe_q,
  input wire [7:0] data_in
);
  // ------------------------------------------------------------------
  // Commands and states
  // ------------------------------------------------------------------
  localparam OP_READ = 2'h0;
  localparam OP_PROG = 2'h1;
  localparam OP_CHECK = 2'h2;
  localparam OP_ID = 2'h3;
  localparam S_IDLE = 7'h01;
  localparam S_SETUP = 7'h02;
  localparam S_PULSE = 7'h04;
  localparam S_VFY = 7'h08;
  localparam S_READ = 7'h10;
  localparam S_DONE = 7'h20;
  localparam S_HALT = 7'h40;
  localparam [16:0] PULSE_LD = PULSE_CYC[16:0];

  reg [6:0] state_q;
  reg [1:0] op_q;
  reg [7:0] want_q;
  reg last_q;
  reg [3:0] pulses_q;
  reg tm_load;
  reg [16:0] tm_val;
  wire tm_done;

  epc_timer u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .load(tm_load),
    .load_val(tm_val),
    .done_q(tm_done)
  );

  always @* begin
    tm_load = 1'b0;
    tm_val = {9'h000, `EPC_SETUP_CYC};
    if (clk_en) begin
      case (state_q)
        S_IDLE: begin
          tm_load = cmd_valid & cmd_ready_q;
          tm_val = {9'h000, `EPC_SETUP_CYC};
        end
        S_SETUP: begin
          tm_load = tm_done;
          tm_val = (op_q == OP_PROG) ? PULSE_LD : {9'h000, `EPC_ACCESS_CYC};
        end
        S_PULSE: begin
          tm_load = tm_done;
          tm_val = {9'h000, `EPC_ACCESS_CYC};
        end
        S_VFY: begin
          tm_load = tm_done & (data_in != want_q) & (pulses_q != `EPC_MAX_PULSES);
          tm_val = {9'h000, `EPC_SETUP_CYC};
        end
        default: begin
          tm_load = 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
      op_q <= OP_READ;
      want_q <= 8'hFF;
      last_q <= 1'b0;
      pulses_q <= 4'h0;
      cmd_ready_q <= 1'b1;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 8'h00;
      rsp_err_q <= 1'b0;
      rsp_pulses_q <= 4'h0;
      addr_in_q <= 14'h0000;
      chip_on_n_q <= 1'b1;
      output_on_n_q <= 1'b1;
      burn_pulse_n_q <= 1'b1;
      vpp_high_q <= 1'b0;
      vcc_high_q <= 1'b0;
      id_hv_q <= 1'b0;
      data_out_q <= 8'hFF;
      data_oe_q <= 1'b0;
    end else if (clk_en) begin
      rsp_valid_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (cmd_valid & cmd_ready_q) begin
            cmd_ready_q <= 1'b0;
            op_q <= cmd_op;
            want_q <= cmd_data;
            last_q <= cmd_last;
            pulses_q <= 4'h0;
            chip_on_n_q <= 1'b0;
            state_q <= S_SETUP;
            if (cmd_op == OP_ID) begin
              // R17: other lines low
              addr_in_q <= {13'h0000, cmd_addr[0]};
              // R15: id voltage
              id_hv_q <= 1'b1;
            end else begin
              // R14: any order
              addr_in_q <= cmd_addr;
            end
            if (cmd_op == OP_PROG) begin
              vpp_high_q <= 1'b1;
              vcc_high_q <= 1'b1;
              // R5: full byte driven
              data_out_q <= cmd_data;
              data_oe_q <= 1'b1;
            end else begin
              // R11: normal supplies
              vpp_high_q <= 1'b0;
              vcc_high_q <= 1'b0;
              output_on_n_q <= 1'b0;
            end
          end
        end
        S_SETUP: begin
          // R6: stable before strobe
          if (tm_done) begin
            if (op_q == OP_PROG) begin
              // R7: start pulse
              burn_pulse_n_q <= 1'b0;
              pulses_q <= pulses_q + 4'h1;
              state_q <= S_PULSE;
            end else begin
              state_q <= S_READ;
            end
          end
        end
        S_PULSE: begin
          if (tm_done) begin
            // R7: read back after pulse
            burn_pulse_n_q <= 1'b1;
            data_oe_q <= 1'b0;
            output_on_n_q <= 1'b0;
            state_q <= S_VFY;
          end
        end
        S_VFY: begin
          if (tm_done) begin
            if (data_in == want_q) begin
              // R19: byte good
              state_q <= S_DONE;
              rsp_err_q <= 1'b0;
            end else if (pulses_q == `EPC_MAX_PULSES) begin
              // R8: tenth pulse failed
              state_q <= S_HALT;
              rsp_err_q <= 1'b1;
            end else begin
              output_on_n_q <= 1'b1;
              data_oe_q <= 1'b1;
              state_q <= S_SETUP;
            end
            rsp_data_q <= data_in;
          end
        end
        S_READ: begin
          if (tm_done) begin
            rsp_data_q <= data_in;
            // R11: compare at normal level
            rsp_err_q <= (op_q == OP_CHECK) && (data_in != want_q);
            state_q <= ((op_q == OP_CHECK) && (data_in != want_q)) ? S_HALT : S_DONE;
          end
        end
        S_DONE: begin
          rsp_valid_q <= 1'b1;
          rsp_pulses_q <= pulses_q;
          chip_on_n_q <= 1'b1;
          output_on_n_q <= 1'b1;
          id_hv_q <= 1'b0;
          data_oe_q <= 1'b0;
          if (last_q) begin
            vpp_high_q <= 1'b0;
            vcc_high_q <= 1'b0;
          end
          cmd_ready_q <= 1'b1;
          state_q <= S_IDLE;
        end
        S_HALT: begin
          // R19: stop on failure
          rsp_valid_q <= ~cmd_ready_q & ~rsp_valid_q & (chip_on_n_q == 1'b0);
          rsp_pulses_q <= pulses_q;
          chip_on_n_q <= 1'b1;
          output_on_n_q <= 1'b1;
          burn_pulse_n_q <= 1'b1;
          vpp_high_q <= 1'b0;
          vcc_high_q <= 1'b0;
          id_hv_q <= 1'b0;
          data_oe_q <= 1'b0;
        end
        default: begin
          state_q <= S_IDLE;
          cmd_ready_q <= 1'b1;
        end
      endcase
    end
  end
endmodule

// File: rtl/epc_timer.v
// Down-counter used by the programmer for strobe widths and access waits.
// Assumes the load is taken only while the counter is idle or to restart it.
module epc_timer (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  input wire clk_en,
  // Control
  input wire load,
  input wire [16:0] load_val,
  output reg done_q
);
  reg [16:0] cnt_q;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 17'h00000;
      done_q <= 1'b0;
    end else if (clk_en) begin
      if (load) begin
        cnt_q <= load_val;
        done_q <= 1'b0;
      end else if (cnt_q != 17'h00000) begin
        cnt_q <= cnt_q - 17'h00001;
        done_q <= (cnt_q == 17'h00001);
      end else begin
        done_q <= 1'b0;
      end
    end
  end
endmodule

// File: verif/epc_mem_model.sv
// Behavioural model of the memory on the programmer's pins.
// Assumes the bench resolves nothing: this model returns the data lines seen.
module epc_mem_model #(
  parameter logic [7:0] ID_MFG = 8'h5A, // Arbitrary value.
  parameter logic [7:0] ID_DEV = 8'hA5 // Arbitrary value.
) (
  // Pins from the programmer
  input wire [13:0] addr_in,
  input wire chip_on_n,
  input wire output_on_n,
  input wire burn_pulse_n,
  input wire vpp_high,
  input wire id_hv,
  input wire [7:0] data_out,
  input wire data_oe,
  output logic [7:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:16383];
  logic [7:0] last_q;
  logic [7:0] clr;
  wire rd = !chip_on_n && !output_on_n && burn_pulse_n;
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    last_q = 8'h00;
  end
  // one bit per pulse, only cleared.
  // Clearing one bit per pulse makes the pulse count depend on the data.
  always @(negedge burn_pulse_n) begin
    clr = mem[addr_in] & ~data_out;
    if (vpp_high && !chip_on_n && output_on_n) mem[addr_in] = mem[addr_in] & ~(clr & (~clr + 8'h01));
  end
  // driven byte or floating lines.
  // Floating lines show the inverse of the last value so stale data never passes.
  always @* begin
    if (data_oe) data_in = data_out;
    else if (rd) data_in = id_hv ? (addr_in[0] ? ID_DEV : ID_MFG) : mem[addr_in];
    else data_in = ~last_q;
  end
  always @* if (data_oe || rd) last_q = data_in;
endmodule

// File: verif/epc_prog_properties.sv
// Checks on the programmer's pins and answers.
// Assumes one clock domain; bound to every programmer instance.
module epc_prog_properties #(
  parameter PULSE_CYC = 50
) (
  // Watched ports
  input wire ref_clk,
  input wire rst,
  input wire clk_en,
  input wire cmd_valid,
  input wire cmd_ready_q,
  input wire rsp_valid_q,
  input wire rsp_err_q,
  input wire [3:0] rsp_pulses_q,
  input wire [13:0] addr_in_q,
  input wire chip_on_n_q,
  input wire output_on_n_q,
  input wire burn_pulse_n_q,
  input wire vpp_high_q,
  input wire vcc_high_q,
  input wire id_hv_q,
  input wire [7:0] data_out_q,
  input wire data_oe_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [15:0] low_q;
  logic [3:0] pulses_q;
  logic burn_q;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      low_q <= 16'h0000;
      pulses_q <= 4'h0;
      burn_q <= 1'b1;
    end else begin
      low_q <= burn_pulse_n_q ? 16'h0000 : low_q + 16'h0001;
      burn_q <= burn_pulse_n_q;
      if (cmd_valid && cmd_ready_q && clk_en) pulses_q <= 4'h0;
      else if (burn_q && !burn_pulse_n_q) pulses_q <= pulses_q + 4'h1;
    end
  end
  sequence s_readback;
    !chip_on_n_q && !output_on_n_q && burn_pulse_n_q;
  endsequence
  sequence s_halted;
    !cmd_ready_q [*8];
  endsequence
  chk_burn_setup: assert property ($fell(burn_pulse_n_q) |-> !chip_on_n_q && output_on_n_q
    && vpp_high_q && data_oe_q && $stable(addr_in_q)) else $error("strobe setup");
  chk_burn_hold: assert property (!burn_pulse_n_q && !burn_q |-> $stable(addr_in_q)
    && $stable(data_out_q) && data_oe_q) else $error("strobe hold");
  chk_pulse_width: assert property ($rose(burn_pulse_n_q) |-> low_q >= PULSE_CYC
    && low_q <= PULSE_CYC + 1) else $error("strobe width");
  chk_read_back: assert property ($rose(burn_pulse_n_q) |-> ##[0:40] s_readback)
    else $error("no read-back");
  chk_pulse_count: assert property (rsp_valid_q && pulses_q != 4'h0 |->
    rsp_pulses_q == pulses_q && pulses_q <= 4'hA) else $error("pulse count");
  chk_fail_tenth: assert property (rsp_valid_q && rsp_err_q && pulses_q != 4'h0 |->
    pulses_q == 4'hA ##1 s_halted) else $error("failure");
  chk_id_addr: assert property (id_hv_q && !chip_on_n_q |-> addr_in_q[13:1] == 13'h0000)
    else $error("id address");
  chk_read_supply: assert property (s_readback |-> vcc_high_q == vpp_high_q)
    else $error("supplies");
endmodule
bind epc_prog epc_prog_properties #(.PULSE_CYC(PULSE_CYC)) u_props (.ref_clk(ref_clk),
  .rst(rst), .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_ready_q(cmd_ready_q),
  .rsp_valid_q(rsp_valid_q), .rsp_err_q(rsp_err_q), .rsp_pulses_q(rsp_pulses_q),
  .addr_in_q(addr_in_q), .chip_on_n_q(chip_on_n_q), .output_on_n_q(output_on_n_q),
  .burn_pulse_n_q(burn_pulse_n_q), .vpp_high_q(vpp_high_q), .vcc_high_q(vcc_high_q),
  .id_hv_q(id_hv_q), .data_out_q(data_out_q), .data_oe_q(data_oe_q));

// File: verif/epc_prog_tb.sv
// Bench for the programmer against the memory model.
// Assumes the model and the checker are compiled before it.
module epc_prog_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MFG = 8'h3C; // Arbitrary value.
  localparam logic [7:0] DEV = 8'hC3; // Arbitrary value.
  typedef struct packed {
    logic [1:0] op;
    logic [13:0] a;
    logic [7:0] d;
    logic l;
    logic [7:0] x;
    logic e;
    logic [3:0] p;
  } epc_row_t;
  epc_row_t rows [8] = '{'{2'h1, 14'h0005, 8'hF0, 1'b0, 8'hF0, 1'b0, 4'h4},
    '{2'h1, 14'h3FFF, 8'h7E, 1'b1, 8'h7E, 1'b0, 4'h2},
    '{2'h0, 14'h1234, 8'h00, 1'b0, 8'hFF, 1'b0, 4'h0},
    '{2'h3, 14'h0000, 8'h00, 1'b0, MFG, 1'b0, 4'h0},
    '{2'h3, 14'h0001, 8'h00, 1'b0, DEV, 1'b0, 4'h0},
    '{2'h2, 14'h0005, 8'hF0, 1'b0, 8'hF0, 1'b0, 4'h0},
    '{2'h2, 14'h3FFF, 8'h7E, 1'b0, 8'h7E, 1'b0, 4'h0},
    '{2'h2, 14'h1234, 8'h00, 1'b0, 8'hFF, 1'b1, 4'h0}};
  logic ref_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, cmd_valid = 1'b0, cmd_last = 1'b0, got;
  logic [1:0] cmd_op = 2'h0;
  logic [13:0] cmd_addr = 14'h0000;
  logic [7:0] cmd_data = 8'h00;
  wire cmd_ready_q, rsp_valid_q, rsp_err_q, chip_on_n_q, output_on_n_q, burn_pulse_n_q;
  wire vpp_high_q, vcc_high_q, id_hv_q, data_oe_q;
  wire [3:0] rsp_pulses_q;
  wire [7:0] rsp_data_q, data_out_q, data_in;
  wire [13:0] addr_in_q;
  int n_mismatch = 0, comparisons = 0, cycles = 0;
  epc_prog #(.PULSE_CYC(50)) dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .cmd_last(cmd_last), .cmd_ready_q(cmd_ready_q), .rsp_valid_q(rsp_valid_q),
    .rsp_data_q(rsp_data_q), .rsp_err_q(rsp_err_q), .rsp_pulses_q(rsp_pulses_q),
    .addr_in_q(addr_in_q), .chip_on_n_q(chip_on_n_q), .output_on_n_q(output_on_n_q),
    .burn_pulse_n_q(burn_pulse_n_q), .vpp_high_q(vpp_high_q), .vcc_high_q(vcc_high_q),
    .id_hv_q(id_hv_q), .data_out_q(data_out_q), .data_oe_q(data_oe_q), .data_in(data_in));
  epc_mem_model #(.ID_MFG(MFG), .ID_DEV(DEV)) mem (.addr_in(addr_in_q), .chip_on_n(chip_on_n_q),
    .output_on_n(output_on_n_q), .burn_pulse_n(burn_pulse_n_q), .vpp_high(vpp_high_q),
    .id_hv(id_hv_q), .data_out(data_out_q), .data_oe(data_oe_q), .data_in(data_in));
  initial forever #4 ref_clk = ~ref_clk;
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Holds the command until taken or for 200 cycles, then waits a bounded time for the answer.
  task automatic run_cmd(input logic [1:0] op, input logic [13:0] a, input logic [7:0] d,
      input logic l);
    int k;
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    {cmd_op, cmd_addr, cmd_data, cmd_last} <= {op, a, d, l};
    @(negedge ref_clk);
    for (k = 0; k < 200 && cmd_ready_q !== 1'b1; k++) @(negedge ref_clk);
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    for (k = 0; k < 2000 && rsp_valid_q !== 1'b1; k++) @(negedge ref_clk);
    got = (rsp_valid_q === 1'b1);
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      run_cmd(rows[i].op, rows[i].a, rows[i].d, rows[i].l);
      chk("answer", 8'h01, {7'h00, got});
      chk("data", rows[i].x, rsp_data_q);
      chk("error", {7'h00, rows[i].e}, {7'h00, rsp_err_q});
      if (rows[i].op == 2'h1) chk("pulses", {4'h0, rows[i].p}, {4'h0, rsp_pulses_q});
    end
    // The failed check of the last row halts the block, so it is reset first.
    @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    // A cleared bit cannot come back, so this byte must fail after ten pulses.
    run_cmd(2'h1, 14'h0005, 8'hFF, 1'b1);
    chk("fail answer", 8'h01, {7'h00, got});
    chk("fail pulses", 8'h0A, {4'h0, rsp_pulses_q});
    run_cmd(2'h0, 14'h0000, 8'h00, 1'b0);
    chk("halted", 8'h00, {7'h00, got});
    @(posedge ref_clk);
    rst <= 1'b1;
    @(negedge ref_clk);
    chk("reset pins", 8'h0A, {4'h0, cmd_ready_q, vpp_high_q, chip_on_n_q, data_oe_q});
    @(posedge ref_clk);
    rst <= 1'b0;
    // A command offered while the clock enable is low must not be taken.
    @(posedge ref_clk);
    clk_en <= 1'b0;
    cmd_valid <= 1'b1;
    repeat (4) @(posedge ref_clk);
    cmd_valid <= 1'b0;
    clk_en <= 1'b1;
    @(negedge ref_clk);
    chk("frozen", 8'h03, {6'h00, cmd_ready_q, chip_on_n_q});
    run_cmd(2'h0, 14'h0005, 8'h00, 1'b0);
    chk("kept byte", 8'hF0, rsp_data_q);
    complete_run();
  end
endmodule
